//--- design/hbpc_pkg.sv
// package with constants and types of the half-bridge pwm protection controller
package hbpc_pkg;
  localparam int CLK_PS = 5000;
  localparam int PRECHG_NS = 100;
  localparam int PRECHG_CYC = (PRECHG_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int MINOFF_NS = 150;
  localparam int MINOFF_CYC = (MINOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DT_PS_PER_KOHM = 2625;
  localparam int DT_MIN_NS = 15;
  localparam int DT_MAX_NS = 200;
  localparam int DT_MIN_CYC = (DT_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DT_MAX_CYC = (DT_MAX_NS * 1000) / CLK_PS;
  localparam int SHDN_NS = 2500;
  localparam int SHDN_CYC = (SHDN_NS * 1000) / CLK_PS;
  localparam int SYNC_TOL_PCT = 20;
  localparam int THIRD_Q12 = 1365;
  localparam int PER_W = 12;
  localparam int KOHM_W = 8;

  typedef enum logic [2:0] {
    GS_OFF    = 3'h0,
    GS_DEAD_M = 3'h1,
    GS_MAIN   = 3'h3,
    GS_DEAD_S = 3'h2,
    GS_SYNC   = 3'h6,
    GS_PRECHG = 3'h7
  } hbpc_gate_st_t;

  typedef struct packed {
    logic boot_ok;
    logic buck_mode;
    logic enable;
    logic comp_ok;
    logic high_fb_low;
    logic low_fb_low;
  } hbpc_ch_pins_t;

  typedef struct packed {
    logic ext_sync_pulse;
    logic dt_shdn_low;
    logic dt_adaptive;
    logic undervoltage_enable_in_low;
    logic ovp_above;
    logic ovp_release;
    logic ss_discharged_one;
    logic phase_option;
    hbpc_ch_pins_t [1:0] ch;
  } hbpc_pins_t;

  typedef struct packed {
    hbpc_gate_st_t gs;
    logic [PER_W-1:0] pos;
    logic [5:0] dcnt;
    logic buck;
    logic high;
    logic low;
  } hbpc_ch_t;

  typedef struct packed {
    hbpc_pins_t s1;
    hbpc_pins_t s2;
    hbpc_pins_t s3;
    hbpc_pins_t filt;
    logic sync_prev;
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] ext_cnt;
    logic locked;
    logic [9:0] shdn_cnt;
    logic shdn;
    logic ovp_alarm;
    logic ss_pd;
    logic phase_clock_one;
    logic phase_clock_two;
    logic sync_clock_out;
    hbpc_ch_t [1:0] ch;
  } hbpc_state_t;

  localparam hbpc_state_t HBPC_STATE_RST = '0;
endpackage : hbpc_pkg

//--- design/hbpc_top.sv
// gate sequencing, dead time, shutdown, overvoltage and clocking for two half-bridge legs
//
// Functional notes
// - buck start, boot low: high off, 100ns low pulses
// - boot above threshold: high gate follows pwm
// - boot undervoltage forces that high gate low
// - buck boot undervoltage suspends pwm, restarts precharge
// - boost mode never emits precharge pulses
// - never both gates on; dead time between
// - programmed dead time 2.625ns per kohm, 15-200ns
// - adaptive: turn on after opposite below 1.5V
// - shutdown pin low over 2.5us latches off
// - only undervoltage enable low clears shutdown latch
// - duty from compensation; zero below 1V
// - minimum off-time 150ns worst case each cycle
// - dead time adds to minimum off-time
// - no sync clock: run at oscillator period
// - sync within 20 percent: lock to it
// - two phase clocks, sync out, option sets phase
// - frequency change settles within about 150us
// - overvoltage: channel one off, soft-start held discharged
// - overvoltage release: soft-start restarts channel one
// - overvoltage affects channel one only
// - pulldown released only below 0.3V soft-start
`timescale 1ns/1ps
module hbpc_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire hbpc_pkg::hbpc_pins_t pins_i,
  input wire logic [hbpc_pkg::PER_W-1:0] duty_cmd_one_i,
  input wire logic [hbpc_pkg::PER_W-1:0] duty_cmd_two_i,
  input wire logic [hbpc_pkg::KOHM_W-1:0] dt_kohm_i,
  input wire logic [hbpc_pkg::PER_W-1:0] osc_period_i,
  output logic high_gate_ch_one_o,
  output logic low_gate_ch_one_o,
  output logic high_gate_ch_two_o,
  output logic low_gate_ch_two_o,
  output logic phase_clock_one_o,
  output logic phase_clock_two_o,
  output logic sync_clock_out_o,
  output logic ss_pulldown_one_o,
  output logic shutdown_latched_o,
  output logic sync_locked_o,
  output logic ovp_alarm_o
);
  import hbpc_pkg::*;

  // clamped programmed dead time in clock cycles
  function automatic logic [5:0] dt_cycles(input logic [KOHM_W-1:0] kohm);
    logic [19:0] ps;
    logic [19:0] cyc;
    ps = 20'(kohm) * 20'(DT_PS_PER_KOHM);
    cyc = (ps + 20'(CLK_PS - 1)) / 20'(CLK_PS);
    if (cyc < 20'(DT_MIN_CYC)) begin
      cyc = 20'(DT_MIN_CYC);
    end else if (cyc > 20'(DT_MAX_CYC)) begin
      cyc = 20'(DT_MAX_CYC);
    end
    return cyc[5:0];
  endfunction : dt_cycles

  hbpc_state_t st_r;
  hbpc_state_t st_nxt;
  hbpc_pins_t f;
  logic [5:0] dt_eff;
  logic [PER_W-1:0] tol;
  logic [PER_W-1:0] third;
  logic [PER_W-1:0] off2;
  logic [PER_W-1:0] offs;
  logic [PER_W-1:0] meas;
  logic edge_ext;
  logic in_win;
  logic align;
  logic [12:0] max_on_raw;
  logic [PER_W-1:0] max_on;
  logic [PER_W-1:0] duty_eff [2];
  logic [PER_W-1:0] duty_cmd [2];
  logic [1:0] run;
  logic [1:0] pre;
  logic [1:0] pc;
  logic [1:0] dead_m_done;
  logic [1:0] dead_s_done;

  assign f = st_r.filt;
  assign duty_cmd[0] = duty_cmd_one_i;
  assign duty_cmd[1] = duty_cmd_two_i;
  // adaptive mode has no programmed figure, so the limit budgets the shortest dead time
  assign dt_eff = f.dt_adaptive ? 6'(DT_MIN_CYC) : dt_cycles(dt_kohm_i);
  assign tol = PER_W'((17'(osc_period_i) * 17'(SYNC_TOL_PCT)) / 17'(100));
  assign third = PER_W'((24'(st_r.period) * 24'(THIRD_Q12)) >> 12);
  assign off2 = f.phase_option ? (st_r.period >> 1) : PER_W'(third << 1);
  assign offs = f.phase_option ? (st_r.period >> 2) : third;
  assign meas = st_r.ext_cnt + PER_W'(1);
  assign edge_ext = f.ext_sync_pulse & ~st_r.sync_prev;
  assign in_win = (meas >= osc_period_i - tol) && (meas <= osc_period_i + tol);
  assign align = edge_ext & in_win;
  assign max_on_raw = 13'(st_r.period) - 13'(MINOFF_CYC) - 13'(dt_eff);
  assign max_on = max_on_raw[12] ? '0 : max_on_raw[PER_W-1:0];

  always_comb begin
    st_nxt = st_r;
    // three-stage synchroniser; a change counts once stages two and three agree
    st_nxt.s1 = pins_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.filt = hbpc_pins_t'((st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3)));

    // external sync measurement and lock; a new frequency is taken at the next edge
    st_nxt.sync_prev = f.ext_sync_pulse;
    if (st_r.ext_cnt != {PER_W{1'b1}}) begin
      st_nxt.ext_cnt = st_r.ext_cnt + PER_W'(1);
    end
    if (edge_ext) begin
      st_nxt.ext_cnt = '0;
      st_nxt.locked = in_win;
      if (in_win) begin
        st_nxt.period = meas;
      end
    end else if (meas > osc_period_i + tol) begin
      st_nxt.locked = 1'b0;
    end
    if (!st_nxt.locked) begin
      st_nxt.period = osc_period_i;
    end
    if (align || st_r.cnt >= st_r.period - PER_W'(1)) begin
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + PER_W'(1);
    end
    st_nxt.phase_clock_one = (st_nxt.cnt == '0);
    st_nxt.phase_clock_two = (st_nxt.cnt == off2);
    st_nxt.sync_clock_out = (st_nxt.cnt == offs);

    // emergency shutdown; the set wins over the clear
    if (f.dt_shdn_low) begin
      if (st_r.shdn_cnt != 10'h3FF) begin
        st_nxt.shdn_cnt = st_r.shdn_cnt + 10'h001;
      end
    end else begin
      st_nxt.shdn_cnt = '0;
    end
    if (f.undervoltage_enable_in_low) begin
      st_nxt.shdn = 1'b0;
    end
    if (st_r.shdn_cnt >= 10'(SHDN_CYC)) begin
      st_nxt.shdn = 1'b1;
    end

    // overvoltage on channel one only; pulldown held until soft-start is empty
    if (f.ovp_above) begin
      st_nxt.ovp_alarm = 1'b1;
    end else if (f.ovp_release) begin
      st_nxt.ovp_alarm = 1'b0;
    end
    if (st_r.ovp_alarm || f.ovp_above) begin
      st_nxt.ss_pd = 1'b1;
    end else if (f.ss_discharged_one) begin
      st_nxt.ss_pd = 1'b0;
    end

    // per-channel sequencer, each timed from its own phase clock
    for (int c = 0; c < 2; c++) begin
      pc[c] = (c == 0) ? st_r.phase_clock_one : st_r.phase_clock_two;
      run[c] = f.ch[c].enable & ~st_r.shdn & ~f.undervoltage_enable_in_low
        & (f.ch[c].buck_mode == st_r.ch[c].buck)
        & ~((c == 0) & (st_r.ovp_alarm | st_r.ss_pd | f.ovp_above));
      pre[c] = f.ch[c].buck_mode & ~f.ch[c].boot_ok;
      if (!f.ch[c].comp_ok) begin
        duty_eff[c] = '0;
      end else if (duty_cmd[c] > max_on) begin
        duty_eff[c] = max_on;
      end else begin
        duty_eff[c] = duty_cmd[c];
      end
      // adaptive waits on the gate being turned off, always at least one cycle
      dead_m_done[c] = f.dt_adaptive ?
        (f.ch[c].buck_mode ? f.ch[c].low_fb_low : f.ch[c].high_fb_low) :
        (st_r.ch[c].dcnt >= dt_eff - 6'h01);
      dead_s_done[c] = f.dt_adaptive ?
        (f.ch[c].buck_mode ? f.ch[c].high_fb_low : f.ch[c].low_fb_low) :
        (st_r.ch[c].dcnt >= dt_eff - 6'h01);
      st_nxt.ch[c].buck = f.ch[c].buck_mode;
      st_nxt.ch[c].pos = pc[c] ? '0 :
        ((st_r.ch[c].pos == {PER_W{1'b1}}) ? st_r.ch[c].pos : st_r.ch[c].pos + PER_W'(1));
      st_nxt.ch[c].dcnt = (st_r.ch[c].dcnt == 6'h3F) ? 6'h3F : st_r.ch[c].dcnt + 6'h01;
      unique case (st_r.ch[c].gs)
        GS_OFF: begin
          st_nxt.ch[c].dcnt = '0;
          if (pc[c]) begin
            if (pre[c]) begin
              st_nxt.ch[c].gs = GS_PRECHG;
            end else if (duty_eff[c] != '0) begin
              st_nxt.ch[c].gs = GS_DEAD_M;
            end else begin
              st_nxt.ch[c].gs = GS_DEAD_S;
            end
          end
        end
        GS_PRECHG: begin
          if (st_r.ch[c].pos >= PER_W'(PRECHG_CYC - 1)) begin
            st_nxt.ch[c].gs = GS_OFF;
          end
        end
        GS_DEAD_M: begin
          if (dead_m_done[c]) begin
            st_nxt.ch[c].gs = GS_MAIN;
          end
        end
        GS_MAIN: begin
          st_nxt.ch[c].dcnt = '0;
          if (pre[c]) begin
            st_nxt.ch[c].gs = GS_OFF;
          end else if (st_r.ch[c].pos >= duty_eff[c]) begin
            st_nxt.ch[c].gs = GS_DEAD_S;
          end
        end
        GS_DEAD_S: begin
          if (dead_s_done[c]) begin
            st_nxt.ch[c].gs = GS_SYNC;
          end
        end
        GS_SYNC: begin
          st_nxt.ch[c].dcnt = '0;
          if (pc[c]) begin
            if (pre[c]) begin
              st_nxt.ch[c].gs = GS_PRECHG;
            end else if (duty_eff[c] != '0) begin
              st_nxt.ch[c].gs = GS_DEAD_M;
            end
          end
        end
        default: begin
          st_nxt.ch[c].gs = GS_OFF;
        end
      endcase
      if (!run[c]) begin
        st_nxt.ch[c].gs = GS_OFF;
        st_nxt.ch[c].dcnt = '0;
      end
      // main switch is the high gate in buck, the low gate in boost
      st_nxt.ch[c].high = (f.ch[c].buck_mode ? (st_nxt.ch[c].gs == GS_MAIN)
        : (st_nxt.ch[c].gs == GS_SYNC)) & f.ch[c].boot_ok;
      st_nxt.ch[c].low = f.ch[c].buck_mode ?
        ((st_nxt.ch[c].gs == GS_SYNC) || (st_nxt.ch[c].gs == GS_PRECHG))
        : (st_nxt.ch[c].gs == GS_MAIN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= HBPC_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign high_gate_ch_one_o = st_r.ch[0].high;
  assign low_gate_ch_one_o = st_r.ch[0].low;
  assign high_gate_ch_two_o = st_r.ch[1].high;
  assign low_gate_ch_two_o = st_r.ch[1].low;
  assign phase_clock_one_o = st_r.phase_clock_one;
  assign phase_clock_two_o = st_r.phase_clock_two;
  assign sync_clock_out_o = st_r.sync_clock_out;
  assign ss_pulldown_one_o = st_r.ss_pd;
  assign shutdown_latched_o = st_r.shdn;
  assign sync_locked_o = st_r.locked;
  assign ovp_alarm_o = st_r.ovp_alarm;

  localparam int PRECHG_LEN = PRECHG_CYC;

  sequence shdn_reached_s;
    st_r.shdn_cnt >= 10'(SHDN_CYC);
  endsequence

  sequence prechg_entry_s;
    $rose(st_r.ch[0].gs == GS_PRECHG);
  endsequence

  no_overlap_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !(high_gate_ch_one_o && low_gate_ch_one_o) && !(high_gate_ch_two_o && low_gate_ch_two_o))
    else $error("both gates of one leg on");

  prechg_width_a: assert property (@(posedge clk_i) disable iff (srst_i)
    prechg_entry_s |-> ##[1:PRECHG_LEN] st_r.ch[0].gs != GS_PRECHG)
    else $error("precharge pulse width wrong");

  boot_uv_high_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !f.ch[0].boot_ok |=> !high_gate_ch_one_o)
    else $error("high gate on during boot undervoltage");

  shdn_latch_a: assert property (@(posedge clk_i) disable iff (srst_i)
    shdn_reached_s |=> shutdown_latched_o ##1 (!high_gate_ch_two_o && !low_gate_ch_two_o))
    else $error("shutdown not latched or gates not off");

  shdn_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    shutdown_latched_o && !f.undervoltage_enable_in_low |=> shutdown_latched_o)
    else $error("shutdown latch cleared without undervoltage enable");

  ovp_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ovp_alarm_o |=> !high_gate_ch_one_o && !low_gate_ch_one_o && ss_pulldown_one_o)
    else $error("channel one active during overvoltage");

  duty_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
    st_r.ch[0].gs == GS_MAIN && !f.ch[0].comp_ok |=> st_r.ch[0].gs != GS_MAIN)
    else $error("main gate held with compensation below offset");

  min_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
    st_r.ch[1].gs == GS_MAIN && $stable(st_r.period) && $stable(dt_eff)
      |-> 13'(st_r.ch[1].pos) + 13'(MINOFF_CYC) + 13'(dt_eff) <= 13'(st_r.period))
    else $error("on time eats minimum off time");

  dead_prog_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(low_gate_ch_one_o) && !f.dt_adaptive && $stable(f.dt_adaptive)
      |-> !high_gate_ch_one_o [*3])
    else $error("programmed dead time too short");

  free_run_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !sync_locked_o && !$past(srst_i) |-> st_r.period == $past(osc_period_i))
    else $error("free-running period not the oscillator period");

  lock_win_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(sync_locked_o) |-> st_r.period == $past(meas) && $past(in_win))
    else $error("locked outside the sync window");
endmodule : hbpc_top

//--- verification/hbpc_leg_model.sv
// model of one half-bridge leg: gate feedback comparators and bootstrap supply
`timescale 1ns/1ps
module hbpc_leg_model (
  input wire logic clk_i,
  input wire logic high_i,
  input wire logic low_i,
  input wire logic drain_i,
  input wire logic slow_i,
  output logic high_fb_low_o,
  output logic low_fb_low_o,
  output logic boot_ok_o
);
  int h_off = 99;
  int l_off = 99;
  int chg = 0;
  // a heavy gate load slows the fall, so adaptive dead time must wait longer
  always @(posedge clk_i) begin
    h_off <= high_i ? 0 : (h_off < 99 ? h_off + 1 : h_off);
    l_off <= low_i ? 0 : (l_off < 99 ? l_off + 1 : l_off);
    chg <= drain_i ? 0 : (low_i && chg < 40 ? chg + 1 : chg);
  end
  assign high_fb_low_o = h_off >= (slow_i ? 6 : 1);
  assign low_fb_low_o = l_off >= (slow_i ? 6 : 1);
  // boot supply charges only while the low gate holds the switch node down
  assign boot_ok_o = chg >= 40;
endmodule : hbpc_leg_model

//--- verification/hbpc_top_tb.sv
// self-checking testbench of the half-bridge pwm protection controller
`timescale 1ns/1ps
module hbpc_top_tb;
  import hbpc_pkg::*;
  logic clk_i = 0;
  logic srst_i = 1;
  hbpc_pins_t pins;
  hbpc_pins_t pins_w;
  logic [PER_W-1:0] d1 = 12'h028;
  logic [PER_W-1:0] d2 = 12'h028;
  logic [PER_W-1:0] per_len = 12'h0c8;
  logic [KOHM_W-1:0] kohm = 8'h14;
  logic [1:0] drain = 2'h3;
  logic [1:0] slow = 2'h0;
  logic [1:0] hfb, lfb, bok;
  logic h1, l1, h2, l2, c1, c2, so, pd, sd, lk, ov;
  int err_total = 0;
  int n_tests = 0;
  int seed = 89823;
  int sync_per = 0;
  logic sync_in = 0;
  int hi, lo, z, hi2, n, k, i, w, e;

  always #2.5 clk_i = ~clk_i;

  hbpc_leg_model m0_u (.clk_i(clk_i), .high_i(h1), .low_i(l1), .drain_i(drain[0]),
    .slow_i(slow[0]), .high_fb_low_o(hfb[0]), .low_fb_low_o(lfb[0]), .boot_ok_o(bok[0]));
  hbpc_leg_model m1_u (.clk_i(clk_i), .high_i(h2), .low_i(l2), .drain_i(drain[1]),
    .slow_i(slow[1]), .high_fb_low_o(hfb[1]), .low_fb_low_o(lfb[1]), .boot_ok_o(bok[1]));

  always_comb begin
    pins_w = pins;
    pins_w.ext_sync_pulse = sync_in;
    for (int c = 0; c < 2; c++) begin
      pins_w.ch[c].boot_ok = bok[c];
      pins_w.ch[c].high_fb_low = hfb[c];
      pins_w.ch[c].low_fb_low = lfb[c];
    end
  end

  hbpc_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .pins_i(pins_w), .duty_cmd_one_i(d1),
    .duty_cmd_two_i(d2), .dt_kohm_i(kohm), .osc_period_i(per_len),
    .high_gate_ch_one_o(h1), .low_gate_ch_one_o(l1), .high_gate_ch_two_o(h2),
    .low_gate_ch_two_o(l2), .phase_clock_one_o(c1), .phase_clock_two_o(c2),
    .sync_clock_out_o(so), .ss_pulldown_one_o(pd), .shutdown_latched_o(sd),
    .sync_locked_o(lk), .ovp_alarm_o(ov));

  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task cyc(input int m);
    repeat (m) @(negedge clk_i);
  endtask : cyc

  // waits for a channel one phase pulse, then counts gate activity up to pulse w
  task meas(input int w);
    logic [2:0] pc;
    int j;
    cyc(1);
    for (j = 0; j < 3000 && c1 !== 1'b1; j++) cyc(1);
    {hi, lo, z, hi2, n} = '0;
    do begin
      cyc(1);
      n++;
      hi += h1;
      lo += l1;
      z += !(h1 | l1);
      hi2 += h2;
      pc = {so, c2, c1};
    end while (pc[w] !== 1'b1 && n < 3000);
    if (j >= 3000 || n >= 3000) begin
      err_total++;
      stop_test;
    end
  endtask : meas

  function int dt_exp(int r);
    int v;
    v = (r * 2625 + 4999) / 5000;
    return v < 3 ? 3 : (v > 40 ? 40 : v);
  endfunction : dt_exp

  function int ph_exp(int w, int p, int phase_option_in);
    int t;
    t = (p * THIRD_Q12) >> 12;
    if (w == 0) return p;
    if (w == 1) return phase_option_in ? p / 2 : 2 * t;
    return phase_option_in ? p / 4 : t;
  endfunction : ph_exp

  // pulse high for 150ns, inside the allowed width window
  initial forever begin
    if (sync_per == 0) cyc(1);
    else begin
      sync_in = 1;
      cyc(30);
      sync_in = 0;
      cyc(sync_per - 30);
    end
  end

  always @(negedge clk_i) if (!srst_i) begin
    chk(h1 & l1, 0);
    chk(h2 & l2, 0);
  end

  initial begin
    pins = '0;
    pins.phase_option = 1;
    pins.ch[0] = 6'h1c;
    pins.ch[1] = 6'h1c;
    cyc(4);
    chk({h1, l1, h2, l2, c1, c2, so, pd, sd, lk, ov}, 0);
    srst_i = 0;
    meas(0);
    meas(0);
    chk(hi, 0);
    chk(lo, PRECHG_CYC);
    drain = 2'h0;
    repeat (4) meas(0);
    // dead time delays the turn-on, so it comes out of the commanded on-time
    e = d1 - dt_exp(kohm) + 1;
    chk(hi >= e - 2 && hi <= e + 2, 1);
    drain[0] = 1;
    meas(0);
    meas(0);
    chk(hi, 0);
    chk(lo, PRECHG_CYC);
    chk(hi2 > 0, 1);
    drain[0] = 0;
    repeat (3) meas(0);
    for (k = 0; k < 5; k++) begin
      kohm = k == 0 ? 8'h06 : (k == 1 ? 8'h4c : 8'(6 + ($random(seed) & 255) % 71));
      d1 = 12'(45 + ($random(seed) & 255) % 60);
      meas(0);
      meas(0);
      e = 2 * dt_exp(kohm);
      chk(z >= e - 2 && z <= e + 2, 1);
      e = d1 - dt_exp(kohm) + 1;
      chk(hi >= e - 2 && hi <= e + 2, 1);
    end
    kohm = 8'h14;
    d1 = 12'hfff;
    meas(0);
    meas(0);
    // the limit covers the pwm span, which holds the leading dead time too
    e = per_len - MINOFF_CYC - 2 * dt_exp(kohm) + 1;
    chk(hi <= e && hi >= e - 2, 1);
    pins.ch[0].comp_ok = 0;
    meas(0);
    meas(0);
    chk(hi, 0);
    pins.ch[0].buck_mode = 0;
    drain[0] = 1;
    meas(0);
    meas(0);
    chk(lo, 0);
    pins.ch[0] = 6'h1c;
    drain[0] = 0;
    d1 = 12'h028;
    repeat (3) meas(0);
    pins.dt_adaptive = 1;
    slow = 2'h3;
    meas(0);
    meas(0);
    chk(z >= 12, 1);
    pins.dt_adaptive = 0;
    slow = 2'h0;
    for (i = 0; i < 2; i++) begin
      pins.phase_option = i[0];
      cyc(10);
      for (w = 0; w < 3; w++) begin
        meas(w);
        chk(n, ph_exp(w, 200, i));
      end
    end
    pins.ch[0].enable = 0;
    pins.ch[1].enable = 0;
    sync_per = 220;
    cyc(1500);
    chk(lk, 1);
    meas(0);
    chk(n, 220);
    sync_per = 0;
    cyc(600);
    chk(lk, 0);
    meas(0);
    chk(n, 200);
    sync_per = 300;
    cyc(1500);
    chk(lk, 0);
    sync_per = 0;
    pins.ch[0].enable = 1;
    pins.ch[1].enable = 1;
    cyc(400);
    pins.ovp_above = 1;
    cyc(10);
    chk({ov, pd}, 2'h3);
    meas(0);
    chk(hi + lo, 0);
    chk(hi2 > 0, 1);
    pins.ovp_above = 0;
    pins.ovp_release = 1;
    cyc(10);
    chk({ov, pd}, 2'h1);
    pins.ss_discharged_one = 1;
    cyc(10);
    chk(pd, 0);
    meas(0);
    meas(0);
    chk(hi > 0, 1);
    pins.dt_shdn_low = 1;
    cyc(450);
    pins.dt_shdn_low = 0;
    cyc(10);
    chk(sd, 0);
    pins.dt_shdn_low = 1;
    cyc(530);
    chk(sd, 1);
    meas(0);
    chk(hi + lo + hi2, 0);
    pins.dt_shdn_low = 0;
    cyc(50);
    chk(sd, 1);
    pins.undervoltage_enable_in_low = 1;
    cyc(10);
    pins.undervoltage_enable_in_low = 0;
    cyc(10);
    chk(sd, 0);
    stop_test;
  end
endmodule : hbpc_top_tb
